// file: core/tcs_pkg.sv
// Purpose: Shared constants and types for the timer channel block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Offsets below are the only copy of the register map.

package tcs_pkg;

   // -----------------------------------------------------------------
   // Register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CMD     = 8'h00;  // Channel command, write-only.
   localparam logic [7:0] OFS_MODE    = 8'h04;  // Channel mode, read/write.
   localparam logic [7:0] OFS_COUNT   = 8'h10;  // counter_value.
   localparam logic [7:0] OFS_HOLD_A  = 8'h14;  // hold_a_value.
   localparam logic [7:0] OFS_HOLD_B  = 8'h18;  // hold_b_value.
   localparam logic [7:0] OFS_LIMIT_C = 8'h1c;  // limit_c_value.
   localparam logic [7:0] OFS_STATUS  = 8'h20;  // channel_status.
   localparam logic [7:0] OFS_IEN     = 8'h24;  // interrupt_enable.
   localparam logic [7:0] OFS_IDIS    = 8'h28;  // interrupt_disable.
   localparam logic [7:0] OFS_IMASK   = 8'h2c;  // interrupt_mask.

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CMD_CLKEN  = 0;   // Start the counter clock.
   localparam int CMD_CLKDIS = 1;   // Stop the counter clock, wins over start.
   localparam int CMD_SWTRG  = 2;   // Software trigger.
   localparam int ST_CLK     = 16;  // clock_on_flag.
   localparam int ST_MA      = 17;  // line_a_mirror.
   localparam int ST_MB      = 18;  // line_b_mirror.

   // Event flags visible in each mode (others read zero).
   localparam logic [7:0] WAVE_VIEW = 8'h9d;
   localparam logic [7:0] CAPT_VIEW = 8'hf3;
   // Writable mode bits; the rest read as zero.
   localparam logic [31:0] MODE_WR_MASK = 32'hffc0_8300;

   // -----------------------------------------------------------------
   // Reset values and codes
   // -----------------------------------------------------------------
   localparam logic [31:0] MODE_RST  = 32'h0000_0000;
   localparam logic [15:0] HOLD_RST  = 16'h0000;
   localparam logic [7:0]  IMASK_RST = 8'h00;
   localparam logic [15:0] COUNT_TOP = 16'hffff;
   localparam logic [1:0]  EFF_NONE  = 2'h0;
   localparam logic [1:0]  EFF_SET   = 2'h1;
   localparam logic [1:0]  EFF_CLR   = 2'h2;
   localparam logic [1:0]  EFF_TGL   = 2'h3;

   // Channel mode word as software sees it.
   typedef struct packed {
      logic [1:0] soft_trigger_effect_line_b;  // Bits 31:30.
      logic [1:0] ext_event_effect_line_b;     // Bits 29:28.
      logic [1:0] limit_c_match_effect_line_b; // Bits 27:26.
      logic [1:0] hold_b_match_effect_line_b;  // Bits 25:24.
      logic [1:0] soft_trigger_effect_line_a;  // Bits 23:22.
      logic [5:0] unused_hi;                   // Bits 21:16.
      logic       wave;                        // Bit 15, waveform mode.
      logic [4:0] unused_mid;                  // Bits 14:10.
      logic [1:0] ext_event_edge;              // Bits 9:8, none/rise/fall/both.
      logic [7:0] unused_lo;                   // Bits 7:0.
   } tcs_mode_type;

endpackage : tcs_pkg

// file: core/tcs_channel.sv
// Purpose: One 16-bit timer channel: counter, holds, status, mask, lines.
// Assumes: APB slave with no wait states; pins arrive asynchronous.
// Notes:   Capture loads hold_a on a rising and hold_b on a falling line_a.

`timescale 1ns/1ps

// Functional notes
// - Soft trigger applies two-bit effect to line_a.
// - hold_b match applies effect to line_b.
// - limit_c match applies effect to line_b.
// - External event applies effect to line_b.
// - Soft trigger applies effect to line_b.
// - Counter register read-only, live 16-bit count.
// - Holds reset zero, writable only in waveform.
// - limit_c read/write in both modes.
// - Overflow flag sticky until status read.
// - Load overrun flag, capture mode only.
// - hold_a/hold_b match flags, waveform only.
// - limit_c match flag in either mode.
// - hold_a/hold_b loaded flags, capture only.
// - External trigger flag sticky until read.
// - Bit 16 shows live clock enable.
// - Bits 17/18 mirror line_a and line_b.
// - Enable register sets mask bits on ones.
// - Disable register clears mask bits on ones.
// - Mask register read-only, resets to zero.
module tcs_channel
   import tcs_pkg::*;
(
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Timer lines a and b split into level, drive and enable; the event input is level only.
   input  wire logic        line_a_level,
   output logic             line_a_drive,
   output logic             line_a_oe,
   input  wire logic        line_b_level,
   output logic             line_b_drive,
   output logic             line_b_oe,
   input  wire logic        ext_event_level,
   // Channel interrupt.
   output logic             irq
);

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------

   // Applies a two-bit effect code to the present line level.
   function automatic logic effect(input logic cur, input logic [1:0] code);
      case (code)
         EFF_SET: effect = 1'b1;
         EFF_CLR: effect = 1'b0;
         EFF_TGL: effect = ~cur;
         default: effect = cur;
      endcase
   endfunction : effect

   // True for every offset that the slave answers.
   function automatic logic mapped(input logic [7:0] a);
      case (a)
         OFS_CMD, OFS_MODE, OFS_COUNT, OFS_HOLD_A, OFS_HOLD_B,
         OFS_LIMIT_C, OFS_STATUS, OFS_IEN, OFS_IDIS, OFS_IMASK: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction : mapped

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [1:0]   a_sync_reg, a_sync_next;     // line_a synchroniser.
   logic [1:0]   b_sync_reg, b_sync_next;     // line_b synchroniser.
   logic [1:0]   e_sync_reg, e_sync_next;     // External event synchroniser.
   logic         a_prev_reg, a_prev_next;     // Last synced line_a.
   logic         e_prev_reg, e_prev_next;     // Last synced event line.
   logic [15:0]  count_reg, count_next;       // count_now.
   logic         clock_on_reg, clock_on_next; // Counter clock enabled.
   tcs_mode_type mode_reg, mode_next;         // Channel mode.
   logic [15:0]  hold_a_reg, hold_a_next;     // hold_a.
   logic [15:0]  hold_b_reg, hold_b_next;     // hold_b.
   logic [15:0]  limit_c_reg, limit_c_next;   // limit_c.
   logic         unread_a_reg, unread_a_next; // hold_a loaded, not yet read.
   logic         unread_b_reg, unread_b_next; // hold_b loaded, not yet read.
   logic [7:0]   flags_reg, flags_next;       // Sticky event flags.
   logic [7:0]   imask_reg, imask_next;       // Interrupt mask.
   logic         line_a_reg, line_a_next;     // Driven line_a level.
   logic         line_b_reg, line_b_next;     // Driven line_b level.
   logic [31:0]  rdata_reg, rdata_next;       // Read data, latched in setup.

   // -----------------------------------------------------------------
   // Bus decode and events
   // -----------------------------------------------------------------
   logic       setup_rd;   // Read setup cycle.
   logic       wr;         // Write access that completes this edge.
   logic       rd;         // Read access that completes this edge.
   logic       wave;       // Waveform mode.
   logic       sw_trig;    // Software trigger command.
   logic       ext_ev;     // Selected external event edge.
   logic       load_a;     // hold_a captures the count.
   logic       load_b;     // hold_b captures the count.
   logic       match_a;    // Count equals hold_a while counting.
   logic       match_b;    // Count equals hold_b while counting.
   logic       match_c;    // Count equals limit_c while counting.
   logic       ovf;        // Counter wraps this edge.
   logic       overrun;    // Load onto an unread hold.
   logic [7:0] view;       // Flags visible in the present mode.
   logic [7:0] events;     // Event pulses in flag order.

   // Decodes requests and derives the single-cycle event pulses.
   always_comb begin
      setup_rd = psel & ~penable & ~pwrite;
      wr       = psel & penable & pwrite;
      rd       = psel & penable & ~pwrite;
      wave     = mode_reg.wave;
      sw_trig  = wr && (paddr == OFS_CMD) && pwdata[CMD_SWTRG];
      case (mode_reg.ext_event_edge)
         2'h1:    ext_ev = e_sync_reg[1] & ~e_prev_reg;
         2'h2:    ext_ev = ~e_sync_reg[1] & e_prev_reg;
         2'h3:    ext_ev = e_sync_reg[1] ^ e_prev_reg;
         default: ext_ev = 1'b0;
      endcase
      load_a  = ~wave & a_sync_reg[1] & ~a_prev_reg;
      load_b  = ~wave & ~a_sync_reg[1] & a_prev_reg;
      match_a = wave & clock_on_reg & (count_reg == hold_a_reg);
      match_b = wave & clock_on_reg & (count_reg == hold_b_reg);
      match_c = clock_on_reg & (count_reg == limit_c_reg);
      ovf     = clock_on_reg & (count_reg == COUNT_TOP);
      overrun = (load_a & unread_a_reg) | (load_b & unread_b_reg);
      view    = wave ? WAVE_VIEW : CAPT_VIEW;
      events  = {ext_ev, load_b, load_a, match_c, match_b, match_a, overrun, ovf};
   end

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------

   // Two flops per pin; only the second stage feeds any logic.
   always_comb begin
      a_sync_next = {a_sync_reg[0], line_a_level};
      b_sync_next = {b_sync_reg[0], line_b_level};
      e_sync_next = {e_sync_reg[0], ext_event_level};
      a_prev_next = a_sync_reg[1];
      e_prev_next = e_sync_reg[1];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_sync_reg <= 2'h0;
         b_sync_reg <= 2'h0;
         e_sync_reg <= 2'h0;
         a_prev_reg <= 1'b0;
         e_prev_reg <= 1'b0;
      end else begin
         a_sync_reg <= a_sync_next;
         b_sync_reg <= b_sync_next;
         e_sync_reg <= e_sync_next;
         a_prev_reg <= a_prev_next;
         e_prev_reg <= e_prev_next;
      end
   end

   // -----------------------------------------------------------------
   // Counter
   // -----------------------------------------------------------------

   // Counts every pclk while enabled; a soft trigger restarts from zero.
   always_comb begin
      count_next    = count_reg;
      clock_on_next = clock_on_reg;
      if (wr && (paddr == OFS_CMD)) begin
         if (pwdata[CMD_CLKEN]) begin
            clock_on_next = 1'b1;
         end
         // Disable wins so a command with both bits leaves it stopped.
         if (pwdata[CMD_CLKDIS]) begin
            clock_on_next = 1'b0;
         end
      end
      if (sw_trig) begin
         count_next = 16'h0000;
      end else if (clock_on_reg) begin
         count_next = 16'(count_reg + 16'h0001);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg    <= HOLD_RST;
         clock_on_reg <= 1'b0;
      end else begin
         count_reg    <= count_next;
         clock_on_reg <= clock_on_next;
      end
   end

   // -----------------------------------------------------------------
   // Software registers
   // -----------------------------------------------------------------

   // Mode, holds, limit and mask; writes land at the access edge.
   always_comb begin
      mode_next     = mode_reg;
      hold_a_next   = hold_a_reg;
      hold_b_next   = hold_b_reg;
      limit_c_next  = limit_c_reg;
      imask_next    = imask_reg;
      unread_a_next = unread_a_reg;
      unread_b_next = unread_b_reg;
      if (wr) begin
         case (paddr)
            OFS_MODE:    mode_next = tcs_mode_type'(pwdata & MODE_WR_MASK);
            OFS_LIMIT_C: limit_c_next = pwdata[15:0];
            OFS_IEN:     imask_next = imask_reg | pwdata[7:0];
            OFS_IDIS:    imask_next = imask_reg & ~pwdata[7:0];
            default:     mode_next = mode_reg;
         endcase
      end
      // Software may only write the holds in waveform mode.
      if (wr && wave && (paddr == OFS_HOLD_A)) begin
         hold_a_next = pwdata[15:0];
      end
      if (wr && wave && (paddr == OFS_HOLD_B)) begin
         hold_b_next = pwdata[15:0];
      end
      // A read clears the unread mark, but a load in the same cycle wins.
      if (rd && (paddr == OFS_HOLD_A)) begin
         unread_a_next = 1'b0;
      end
      if (rd && (paddr == OFS_HOLD_B)) begin
         unread_b_next = 1'b0;
      end
      if (load_a) begin
         hold_a_next   = count_reg;
         unread_a_next = 1'b1;
      end
      if (load_b) begin
         hold_b_next   = count_reg;
         unread_b_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg     <= tcs_mode_type'(MODE_RST);
         hold_a_reg   <= HOLD_RST;
         hold_b_reg   <= HOLD_RST;
         limit_c_reg  <= HOLD_RST;
         imask_reg    <= IMASK_RST;
         unread_a_reg <= 1'b0;
         unread_b_reg <= 1'b0;
      end else begin
         mode_reg     <= mode_next;
         hold_a_reg   <= hold_a_next;
         hold_b_reg   <= hold_b_next;
         limit_c_reg  <= limit_c_next;
         imask_reg    <= imask_next;
         unread_a_reg <= unread_a_next;
         unread_b_reg <= unread_b_next;
      end
   end

   // -----------------------------------------------------------------
   // Status flags
   // -----------------------------------------------------------------

   // A status read clears only what it reported plus hidden bits, so an
   // event between setup and access edges is kept; a new event wins.
   always_comb begin
      flags_next = flags_reg;
      if (rd && (paddr == OFS_STATUS)) begin
         flags_next = flags_reg & ~(rdata_reg[7:0] | ~view);
      end
      flags_next = flags_next | events;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_reg <= 8'h00;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // -----------------------------------------------------------------
   // Waveform lines
   // -----------------------------------------------------------------

   // When several line_b events coincide, only the highest one acts:
   // soft trigger, then external event, then limit_c, then hold_b.
   always_comb begin
      line_a_next = line_a_reg;
      line_b_next = line_b_reg;
      if (wave) begin
         if (sw_trig) begin
            line_a_next = effect(line_a_reg, mode_reg.soft_trigger_effect_line_a);
            line_b_next = effect(line_b_reg, mode_reg.soft_trigger_effect_line_b);
         end else if (ext_ev) begin
            line_b_next = effect(line_b_reg, mode_reg.ext_event_effect_line_b);
         end else if (match_c) begin
            line_b_next = effect(line_b_reg, mode_reg.limit_c_match_effect_line_b);
         end else if (match_b) begin
            line_b_next = effect(line_b_reg, mode_reg.hold_b_match_effect_line_b);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_a_reg <= 1'b0;
         line_b_reg <= 1'b0;
      end else begin
         line_a_reg <= line_a_next;
         line_b_reg <= line_b_next;
      end
   end

   // -----------------------------------------------------------------
   // Read data
   // -----------------------------------------------------------------

   // Read data is latched in the setup cycle and held through access.
   always_comb begin
      rdata_next = rdata_reg;
      if (setup_rd) begin
         rdata_next = 32'h0000_0000;
         case (paddr)
            OFS_MODE:    rdata_next = mode_reg;
            OFS_COUNT:   rdata_next[15:0] = count_reg;
            OFS_HOLD_A:  rdata_next[15:0] = hold_a_reg;
            OFS_HOLD_B:  rdata_next[15:0] = hold_b_reg;
            OFS_LIMIT_C: rdata_next[15:0] = limit_c_reg;
            OFS_IMASK:   rdata_next[7:0] = imask_reg;
            OFS_STATUS: begin
               rdata_next[7:0]   = flags_reg & view;
               rdata_next[ST_CLK] = clock_on_reg;
               rdata_next[ST_MA] = wave ? line_a_reg : a_sync_reg[1];
               rdata_next[ST_MB] = wave ? line_b_reg : b_sync_reg[1];
            end
            default:     rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign prdata       = rdata_reg;
   assign pready       = 1'b1;
   assign pslverr      = psel & penable & ~mapped(paddr);
   assign line_a_drive = line_a_reg;
   assign line_b_drive = line_b_reg;
   assign line_a_oe    = wave;
   assign line_b_oe    = wave;
   assign irq          = |(flags_reg & view & imask_reg);

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_sw_line_a;
      wave && sw_trig && mode_reg.soft_trigger_effect_line_a == EFF_TGL
      |=> line_a_drive != $past(line_a_reg);
   endproperty
   a_sw_line_a: assert property (p_sw_line_a) else $error("line_a not toggled");

   property p_hold_b_line_b;
      wave && match_b && !sw_trig && !ext_ev && !match_c
      && mode_reg.hold_b_match_effect_line_b == EFF_SET |=> line_b_drive;
   endproperty
   a_hold_b_line_b: assert property (p_hold_b_line_b) else $error("line_b not set");

   property p_limit_line_b;
      wave && match_c && !sw_trig && !ext_ev
      && mode_reg.limit_c_match_effect_line_b == EFF_CLR |=> !line_b_drive;
   endproperty
   a_limit_line_b: assert property (p_limit_line_b) else $error("line_b not cleared");

   property p_sw_line_b;
      wave && sw_trig && mode_reg.soft_trigger_effect_line_b == EFF_NONE
      |=> $stable(line_b_drive);
   endproperty
   a_sw_line_b: assert property (p_sw_line_b) else $error("line_b moved");

   property p_count_read;
      setup_rd && paddr == OFS_COUNT |=> prdata == {16'h0000, $past(count_reg)};
   endproperty
   a_count_read: assert property (p_count_read) else $error("bad count read");

   property p_hold_locked;
      !wave && !load_a |=> $stable(hold_a_reg);
   endproperty
   a_hold_locked: assert property (p_hold_locked) else $error("hold_a changed");

   property p_ovf_sticky;
      ovf ##1 !(rd && paddr == OFS_STATUS) |=> flags_reg[0];
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow lost");

   property p_overrun;
      !wave && load_a && unread_a_reg |=> flags_reg[1];
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun missed");

   property p_mask_en;
      wr && paddr == OFS_IEN |=> (imask_reg & $past(pwdata[7:0])) == $past(pwdata[7:0]);
   endproperty
   a_mask_en: assert property (p_mask_en) else $error("mask not set");

   property p_mask_dis;
      wr && paddr == OFS_IDIS |=> (imask_reg & $past(pwdata[7:0])) == 8'h00;
   endproperty
   a_mask_dis: assert property (p_mask_dis) else $error("mask not cleared");

   // An enabled event must raise the line one edge later, whatever the flag held.
   property p_irq;
      |(events & imask_reg) && !wr |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

   c_overflow: cover property (ovf ##1 irq);
   c_overrun:  cover property (load_a && unread_a_reg);
   c_toggle:   cover property (wave && sw_trig ##1 line_b_drive);
   c_status:   cover property (rd && paddr == OFS_STATUS && rdata_reg[4]);

endmodule : tcs_channel

// file: dv/tcs_pins_model.sv
// Purpose: Far-side model of the two timer lines and the event input.
// Assumes: The bench sets the level of each pin that the channel leaves undriven.
// Notes:   A line that the channel enables shows the channel's own level.
`timescale 1ns/1ps
module tcs_pins_model (
   // Channel drive side.
   input  wire logic line_a_drive,
   input  wire logic line_a_oe,
   input  wire logic line_b_drive,
   input  wire logic line_b_oe,
   // Levels the outside world would put on free pins.
   input  wire logic a_want,
   input  wire logic b_want,
   input  wire logic ev_want,
   // Resolved pin levels.
   output logic      line_a_level,
   output logic      line_b_level,
   output logic      ext_event_level
);
   // The channel wins while its enable is high, so a mirror reads its own drive.
   assign line_a_level    = line_a_oe ? line_a_drive : a_want;
   assign line_b_level    = line_b_oe ? line_b_drive : b_want;
   assign ext_event_level = ev_want;
endmodule : tcs_pins_model

// file: dv/testbench.sv
// Purpose: Self-checking bench for the timer channel registers and lines.
// Assumes: Zero-wait APB slave; pin synchronisers need a few cycles.
// Notes:   The overflow scenario alone runs a full 65536-cycle wrap.
`timescale 1ns/1ps
module testbench;
   import tcs_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, err, la_l, la_d, la_oe, lb_l, lb_d, lb_oe, ev_l, irq;
   logic a_w = 1'b0, b_w = 1'b0, ev_w = 1'b0, ea, eb;
   int bad_count = 0, checks_done = 0, n;
   tcs_mode_type m;
   logic [1:0] codes [5] = '{EFF_SET, EFF_TGL, EFF_CLR, EFF_TGL, EFF_NONE};
   always #2.5 pclk = ~pclk;
   tcs_channel dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .line_a_level(la_l), .line_a_drive(la_d), .line_a_oe(la_oe),
      .line_b_level(lb_l), .line_b_drive(lb_d), .line_b_oe(lb_oe),
      .ext_event_level(ev_l), .irq(irq));
   tcs_pins_model pins_u (.line_a_drive(la_d), .line_a_oe(la_oe), .line_b_drive(lb_d),
      .line_b_oe(lb_oe), .a_want(a_w), .b_want(b_w), .ev_want(ev_w),
      .line_a_level(la_l), .line_b_level(lb_l), .ext_event_level(ev_l));
   task automatic close_out;
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         chk(32'h1, 32'h0);
         close_out();
      end
      q = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic t_regs;
      apb(0, OFS_HOLD_A, 0); chk(q, 0);
      apb(0, OFS_IMASK, 0); chk(q, 0);
      apb(0, 8'h3c, 0); chk(err, 1);
      apb(1, OFS_LIMIT_C, 32'h1234); apb(0, OFS_LIMIT_C, 0); chk(q, 32'h1234);
      apb(1, OFS_HOLD_B, 32'h55); apb(0, OFS_HOLD_B, 0); chk(q, 0);
      apb(1, OFS_COUNT, 32'h77ff); apb(0, OFS_COUNT, 0); chk(q, 0);
      apb(1, OFS_IEN, 32'hff); apb(1, OFS_IDIS, 32'h0f); apb(1, OFS_IEN, 0);
      apb(0, OFS_IMASK, 0); chk(q, 32'hf0);
      apb(1, OFS_IDIS, 32'hff); apb(0, OFS_IMASK, 0); chk(q, 0);
   endtask : t_regs
   // Capture: a line_a pulse loads both holds; a second pulse overruns.
   task automatic t_capture;
      m = '0; m.ext_event_edge = 2'h1;
      apb(1, OFS_MODE, m); apb(1, OFS_CMD, 32'h1);
      apb(0, OFS_STATUS, 0); chk(q[16], 1);
      for (int i = 0; i < 2; i++) begin
         a_w <= 1'b1; repeat (8) @(posedge pclk);
         a_w <= 1'b0; repeat (8) @(posedge pclk);
         apb(0, OFS_STATUS, 0); chk(q & 32'h20062, 32'h60 | (i << 1));
      end
      ev_w <= 1'b1; repeat (8) @(posedge pclk);
      apb(0, OFS_STATUS, 0); chk(q[7], 1);
      ev_w <= 1'b0; apb(1, OFS_CMD, 32'h2);
   endtask : t_capture
   // Waveform: soft trigger drives both lines with each effect code.
   task automatic t_soft;
      for (int i = 0; i < 5; i++) begin
         m = '0; m.wave = 1'b1;
         m.soft_trigger_effect_line_a = codes[i]; m.soft_trigger_effect_line_b = codes[i];
         apb(1, OFS_MODE, m); apb(1, OFS_CMD, 32'h4);
         repeat (4) @(posedge pclk);
         ea = (codes[i] == EFF_SET) ? 1'b1 : (codes[i] == EFF_CLR) ? 1'b0 :
              (codes[i] == EFF_TGL) ? ~ea : ea;
         eb = ea;
         chk({lb_d, la_d}, {eb, ea});
         apb(0, OFS_STATUS, 0); chk(q[18:17], {eb, ea});
      end
   endtask : t_soft
   // Waveform: hold_b match sets line_b, a rising external edge toggles it.
   task automatic t_events;
      m = '0; m.wave = 1'b1; m.ext_event_edge = 2'h1; m.ext_event_effect_line_b = EFF_TGL;
      m.soft_trigger_effect_line_b = EFF_CLR; m.hold_b_match_effect_line_b = EFF_SET;
      apb(1, OFS_MODE, m); apb(1, OFS_HOLD_B, 32'h20); apb(1, OFS_HOLD_A, 32'h10);
      apb(0, OFS_HOLD_B, 0); chk(q, 32'h20);
      apb(0, OFS_STATUS, 0); apb(1, OFS_CMD, 32'h5);
      repeat (40) @(posedge pclk);
      chk(lb_d, 1);
      apb(1, OFS_CMD, 32'h2); apb(0, OFS_STATUS, 0); chk(q[3:2], 2'h3);
      ev_w <= 1'b1; repeat (6) @(posedge pclk);
      chk(lb_d, 0);
      apb(0, OFS_STATUS, 0); chk(q[7], 1);
      ev_w <= 1'b0;
   endtask : t_events
   // Overflow: a full wrap sets the sticky flag and the masked-in interrupt.
   task automatic t_overflow;
      apb(1, OFS_IDIS, 32'h10); apb(1, OFS_IEN, 32'h01); apb(1, OFS_CMD, 32'h5);
      repeat (65540) @(posedge pclk);
      chk(irq, 1); apb(1, OFS_CMD, 32'h2);
      apb(0, OFS_STATUS, 0); chk(q[0], 1);
      apb(0, OFS_STATUS, 0); chk(q[0], 0);
   endtask : t_overflow
   // limit_c match sets line_b, raises the flag and the interrupt.
   task automatic t_limit;
      apb(1, OFS_LIMIT_C, 32'h40); apb(1, OFS_IEN, 32'h10);
      m = '0; m.wave = 1'b1;
      m.soft_trigger_effect_line_b = EFF_CLR; m.limit_c_match_effect_line_b = EFF_SET;
      apb(1, OFS_MODE, m); apb(0, OFS_STATUS, 0); apb(1, OFS_CMD, 32'h5);
      n = 0;
      while (irq !== 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      chk(irq, 1); chk(lb_d, 1);
      if (irq !== 1'b1) close_out();
      apb(1, OFS_CMD, 32'h2); apb(0, OFS_STATUS, 0); chk(q[4], 1);
      apb(0, OFS_STATUS, 0); chk(q[4], 0); chk(irq, 0);
   endtask : t_limit
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_capture();
      t_soft();
      t_events();
      t_limit();
      t_overflow();
      close_out();
   end
endmodule : testbench
